// ---- design/link_ctrl_regs.sv ----
// link control register bank: lane map, sync source, format, scrambler,
// test pattern and identifier, reached over apb
// assumes pins are asynchronous; link layer consumes the decoded outputs
//
// Summary of operation
// - swap clear: lanes 0-3 on, others off
// - swap set: lanes 4-7 on, 0-3 off
// - sync source 0 takes the sync pin
// - source 1 takes timestamp pin, receiver enabled
// - source 2 uses only software sync bit
// - format bit: 0 offset binary, 1 two's complement
// - 8b/10b scrambles when scrambler bit set
// - 64b/66b always scrambles
// - codes 4,5,6: ramp, transport, d21.5
// - codes 7,8,9,16 only in 8b/10b
// - codes 10/11 hold outputs low/high
// - code 15 sends eight zeros, eight ones
// - link a sends id, link b id+1
// - identifier bit zero forced clear
// - link disabled holds block in reset
// - software sync bit low requests resync
`timescale 1ns/1ps
module link_ctrl_regs
    import link_ctrl_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [13:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     single_ended_sync_pin,
    input  wire logic                     timestamp_pin,
    output logic [7:0]                    side_a_lane_on,
    output logic [7:0]                    side_b_lane_on,
    output logic                          sync_request_n,
    output logic                          sample_number_format,
    output logic                          scramble_active,
    output link_ctrl_pkg::pattern_t       pattern_sel,
    output logic                          pattern_unsupported,
    output logic [7:0]                    link_a_ila_id,
    output logic [7:0]                    link_b_ila_id,
    output logic                          link_block_reset,
    output logic                          serializer_power_on,
    output logic                          link_clock_on
);
    import link_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // synchronised pins

    link_cfg_if se_if ();
    link_cfg_if ts_if ();
    assign se_if.raw_pin = single_ended_sync_pin;
    assign ts_if.raw_pin = timestamp_pin;

    pin_sync u_se_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (se_if)
    );
    pin_sync u_ts_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ts_if)
    );

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  test;
        logic [7:0]  dev_id;
        logic [7:0]  enable;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [7:0]  lane_a;
        logic [7:0]  lane_b;
        logic        sync_n;
        logic        fmt;
        logic        scrambler_enable;
        pattern_t    pat;
        logic        pat_bad;
        logic [7:0]  id_a;
        logic [7:0]  id_b;
        logic        blk_rst;
        logic        ser_on;
        logic        clk_on;
    } bank_state_t;

    bank_state_t st_reg, st_next;

    logic       setup;
    logic       wr_lane0;
    logic       known;
    logic [7:0] wbyte;
    logic [7:0] sel_lanes;
    logic       pin_req_n;
    logic       enc66;
    pattern_t   pat_dec;
    logic       pat_8b10b_only;
    logic [7:0] status;

    assign setup    = psel && !penable;
    assign wbyte    = pwdata[7:0];
    assign wr_lane0 = pstrb[0];
    assign enc66    = st_reg.enable[enc66_bit];
    assign status   = {7'h00, st_reg.pat_bad};

    ////////////////////////////////////////////////////////////////////
    // test code decode

    always_comb begin
        pat_8b10b_only = 1'b0;
        case (st_reg.test[4:0])
            5'h00: pat_dec = pat_normal;
            5'h01: pat_dec = pat_prbs7;
            5'h02: pat_dec = pat_prbs15;
            5'h03: pat_dec = pat_prbs23;
            5'h04: pat_dec = pat_ramp;
            5'h05: pat_dec = pat_transport;
            5'h06: pat_dec = pat_d21_5;
            5'h07: begin
                pat_dec = pat_k28_5;
                pat_8b10b_only = 1'b1;
            end
            5'h08: begin
                pat_dec = pat_ila;
                pat_8b10b_only = 1'b1;
            end
            5'h09: begin
                pat_dec = pat_rpat;
                pat_8b10b_only = 1'b1;
            end
            5'h0a: pat_dec = pat_low;
            5'h0b: pat_dec = pat_high;
            5'h0d: pat_dec = pat_prbs9;
            5'h0e: pat_dec = pat_prbs31;
            5'h0f: pat_dec = pat_clock;            // 0x00ff words
            5'h10: begin
                pat_dec = pat_k28_7;
                pat_8b10b_only = 1'b1;
            end
            // reserved codes fall back to normal data
            default: pat_dec = pat_normal;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sync request source

    always_comb begin
        case (sync_source_t'(st_reg.ctrl[sync_lsb +: 2]))
            sync_from_pin:       pin_req_n = se_if.stable_level;
            // timestamp path dead unless its receiver is on
            sync_from_timestamp: pin_req_n =
                ts_if.stable_level || !st_reg.enable[tsrx_bit];
            default:             pin_req_n = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        st_next.ready = 1'b0;
        st_next.err   = 1'b0;
        known = 1'b1;

        // no wait state: answer lands the cycle after setup
        if (setup) begin
            st_next.ready = 1'b1;
            st_next.rdata = 32'h0000_0000;
            if (paddr == link_control_addr) begin
                st_next.rdata[7:0] = {3'h0, st_reg.ctrl[4:0]};
                if (pwrite && wr_lane0) begin
                    st_next.ctrl = {3'h0, wbyte[4:0]};
                end
            end else if (paddr == link_test_pattern_addr) begin
                st_next.rdata[7:0] = {3'h0, st_reg.test[4:0]};
                if (pwrite && wr_lane0) begin
                    st_next.test = {3'h0, wbyte[4:0]};
                end
            end else if (paddr == link_device_id_addr) begin
                st_next.rdata[7:0] = st_reg.dev_id;
                if (pwrite && wr_lane0) begin
                    st_next.dev_id = {wbyte[7:1], 1'b0};
                end
            end else if (paddr == link_enable_addr) begin
                st_next.rdata[7:0] = {4'h0, st_reg.enable[3:0]};
                if (pwrite && wr_lane0) begin
                    st_next.enable = {4'h0, wbyte[3:0]};
                end
            end else if (paddr == link_status_addr) begin
                st_next.rdata[7:0] = status;
            end else begin
                known = 1'b0;
            end
            st_next.err = !known;
            if (pwrite) begin
                st_next.rdata = 32'h0000_0000;
            end
        end

        // lane map: A and B sides each use a 4-lane half
        sel_lanes = st_reg.ctrl[swap_bit] ? 8'hf0 : 8'h0f;
        // trusts software to keep swap to <=8-lane modes
        // control values taken whether or not the link is enabled
        st_next.blk_rst = !st_reg.enable[en_bit];
        st_next.ser_on  = st_reg.enable[en_bit];
        st_next.clk_on  = st_reg.enable[en_bit];
        st_next.lane_a  = st_reg.enable[en_bit] ? sel_lanes : 8'h00;
        st_next.lane_b  = st_reg.enable[en_bit] ? sel_lanes : 8'h00;
        // either source can pull the request low
        st_next.sync_n  = pin_req_n && st_reg.enable[swsync_bit];
        st_next.fmt     = st_reg.ctrl[fmt_bit];
        st_next.scrambler_enable     = enc66 || st_reg.ctrl[scr_bit];
        st_next.pat_bad = pat_8b10b_only && enc66;
        st_next.pat     = st_next.pat_bad ? pat_normal : pat_dec;
        st_next.id_a    = st_reg.dev_id;
        st_next.id_b    = st_reg.dev_id + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{
                ctrl:    link_control_rst,
                test:    link_test_rst,
                dev_id:  link_device_id_rst,
                enable:  link_enable_rst,
                rdata:   32'h0000_0000,
                ready:   1'b0,
                err:     1'b0,
                lane_a:  8'h00,
                lane_b:  8'h00,
                sync_n:  1'b1,
                fmt:     1'b1,
                scrambler_enable:     1'b1,
                pat:     pat_normal,
                pat_bad: 1'b0,
                id_a:    8'h00,
                id_b:    8'h01,
                blk_rst: 1'b1,
                ser_on:  1'b0,
                clk_on:  1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign prdata               = st_reg.rdata;
    assign pready               = st_reg.ready;
    assign pslverr              = st_reg.err;
    assign side_a_lane_on       = st_reg.lane_a;
    assign side_b_lane_on       = st_reg.lane_b;
    assign sync_request_n       = st_reg.sync_n;
    assign sample_number_format = st_reg.fmt;
    assign scramble_active      = st_reg.scrambler_enable;
    assign pattern_sel          = st_reg.pat;
    assign pattern_unsupported  = st_reg.pat_bad;
    assign link_a_ila_id        = st_reg.id_a;
    assign link_b_ila_id        = st_reg.id_b;
    assign link_block_reset     = st_reg.blk_rst;
    assign serializer_power_on  = st_reg.ser_on;
    assign link_clock_on        = st_reg.clk_on;
endmodule // link_ctrl_regs

// ---- design/link_ctrl_pkg.sv ----
// package for the link control register bank: offsets, resets, encodings
// assumes a 32-bit apb slave, byte addresses 4x the printed index
package link_ctrl_pkg;
    localparam logic [11:0] link_control_idx       = 12'h204;
    localparam logic [11:0] link_test_pattern_idx  = 12'h205;
    localparam logic [11:0] link_device_id_idx     = 12'h206;
    // own choice: register holding link enable, sync request, mode bits
    localparam logic [11:0] link_enable_idx        = 12'h200;
    localparam logic [11:0] link_status_idx        = 12'h208;
    localparam logic [13:0] link_control_addr      = {link_control_idx, 2'b00};
    localparam logic [13:0] link_test_pattern_addr = {link_test_pattern_idx, 2'b00};
    localparam logic [13:0] link_device_id_addr    = {link_device_id_idx, 2'b00};
    localparam logic [13:0] link_enable_addr       = {link_enable_idx, 2'b00};
    localparam logic [13:0] link_status_addr       = {link_status_idx, 2'b00};

    localparam logic [7:0] link_control_rst   = 8'h03;
    localparam logic [7:0] link_test_rst      = 8'h00;
    localparam logic [7:0] link_device_id_rst = 8'h00;
    // bit0 link_enable, bit1 software_sync_request_n,
    // bit2 timestamp_receiver_enable, bit3 64b/66b mode
    localparam logic [7:0] link_enable_rst    = 8'h03;

    localparam int scr_bit      = 0;
    localparam int fmt_bit      = 1;
    localparam int sync_lsb     = 2;
    localparam int swap_bit     = 4;
    localparam int en_bit       = 0;
    localparam int swsync_bit   = 1;
    localparam int tsrx_bit     = 2;
    localparam int enc66_bit    = 3;
    localparam int sync_stages  = 3;

    typedef enum logic [1:0] {
        sync_from_pin       = 2'h0,
        sync_from_timestamp = 2'h1,
        sync_from_software  = 2'h2
    } sync_source_t;

    typedef enum logic [3:0] {
        pat_normal, pat_prbs7, pat_prbs9, pat_prbs15, pat_prbs23,
        pat_prbs31, pat_ramp, pat_transport, pat_d21_5, pat_k28_5,
        pat_ila, pat_rpat, pat_low, pat_high, pat_clock, pat_k28_7
    } pattern_t;
endpackage

// ---- design/link_cfg_if.sv ----
// carrier between the register bank and the pin synchroniser
// assumes both sides on pclk
`timescale 1ns/1ps
interface link_cfg_if;
    logic raw_pin;
    logic stable_level;
    modport sync (input raw_pin, output stable_level);
    modport bank (output raw_pin, input stable_level);
endinterface

// ---- design/pin_sync.sv ----
// three-stage synchroniser; the level changes once stages 2 and 3 agree
// assumes an asynchronous pin, reset level high (no request)
`timescale 1ns/1ps
module pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    link_cfg_if.sync  pin
);
    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } sync_state_t;
    sync_state_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.stages = {st_reg.stages[1:0], pin.raw_pin};
        if (st_reg.stages[1] == st_reg.stages[2]) begin
            st_next.level = st_reg.stages[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{stages: 3'h7, level: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin.stable_level = st_reg.level;
endmodule // pin_sync

// ---- sim/sync_request_model.sv ----
// far-end receiver stand-in: drives the two sync request pins
// assumes the bench commands each resync; pins are active low
`timescale 1ns/1ps
module sync_request_model (
    input  wire logic pclk,
    input  wire logic want_pin_sync,
    input  wire logic want_ts_sync,
    output logic      single_ended_sync_pin,
    output logic      timestamp_pin
);
    // idle high: a floating low would read as a resync request
    initial begin
        single_ended_sync_pin = 1'b1;
        timestamp_pin = 1'b1;
    end
    always @(posedge pclk) begin
        single_ended_sync_pin <= !want_pin_sync;
        timestamp_pin <= !want_ts_sync;
    end
endmodule // sync_request_model

// ---- sim/link_ctrl_regs_assertions.sv ----
// concurrent checks on the link control register bank ports
// assumes one pclk domain, presetn asynchronous active low
`timescale 1ns/1ps
module link_ctrl_regs_assertions
    import link_ctrl_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [13:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [7:0]           side_a_lane_on,
    input wire logic [7:0]           side_b_lane_on,
    input wire logic                 sample_number_format,
    input wire logic                 scramble_active,
    input wire link_ctrl_pkg::pattern_t pattern_sel,
    input wire logic                 pattern_unsupported,
    input wire logic [7:0]           link_a_ila_id,
    input wire logic [7:0]           link_b_ila_id,
    input wire logic                 link_block_reset,
    input wire logic                 serializer_power_on,
    input wire logic                 link_clock_on
);
    logic set_wr;
    assign set_wr = psel && !penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    idle_lanes_a: assert property (
        link_block_reset |-> side_a_lane_on == 8'h00 && !link_clock_on
        && side_b_lane_on == 8'h00 && !serializer_power_on)
        else $error("lanes active while link disabled");
    lane_map_a: assert property (
        !link_block_reset |-> side_a_lane_on inside {8'h0f, 8'hf0}
        && side_b_lane_on == side_a_lane_on)
        else $error("lane mask not a legal half");
    id_pair_a: assert property (
        link_b_ila_id == link_a_ila_id + 8'h01)
        else $error("link b identifier not a plus one");
    id_even_a: assert property (
        set_wr && paddr == link_device_id_addr |->
        ##2 link_a_ila_id == {$past(pwdata[7:1], 2), 1'b0})
        else $error("identifier not forced even");
    format_follow_a: assert property (
        set_wr && paddr == link_control_addr |->
        ##2 sample_number_format == $past(pwdata[1], 2))
        else $error("sample format not following control");
    scramble_on_a: assert property (
        set_wr && paddr == link_control_addr && pwdata[0] |->
        ##2 scramble_active)
        else $error("scrambler off with bit set");
    hold_low_a: assert property (
        set_wr && paddr == link_test_pattern_addr && pwdata[4:0] == 5'd10
        |-> ##2 pattern_sel == pat_low)
        else $error("held low pattern not selected");
    unsup_normal_a: assert property (
        pattern_unsupported |-> pattern_sel == pat_normal)
        else $error("unsupported pattern still selected");
    cover property (link_block_reset ##1 !link_block_reset);
    cover property (side_a_lane_on == 8'hf0);
    cover property (pattern_unsupported);
endmodule // link_ctrl_regs_assertions

bind link_ctrl_regs link_ctrl_regs_assertions u_link_ctrl_regs_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .side_a_lane_on(side_a_lane_on), .side_b_lane_on(side_b_lane_on),
    .sample_number_format(sample_number_format),
    .scramble_active(scramble_active), .pattern_sel(pattern_sel),
    .pattern_unsupported(pattern_unsupported),
    .link_a_ila_id(link_a_ila_id), .link_b_ila_id(link_b_ila_id),
    .link_block_reset(link_block_reset),
    .serializer_power_on(serializer_power_on),
    .link_clock_on(link_clock_on));

// ---- sim/serial_link_control_regs_tb_top.sv ----
// self-checking bench for the link control register bank over apb
// assumes one 40 MHz clock and the sync request model on the pins
`timescale 1ns/1ps
module serial_link_control_regs_tb_top;
    import link_ctrl_pkg::*;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, er, want_pin, want_ts;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, se_pin, ts_pin, sync_request_n, fmt, scrambler_enable;
    logic pat_bad, blk_rst, ser_on, clk_on;
    logic [7:0] lane_a, lane_b, id_a, id_b;
    pattern_t pattern_sel;
    int miscompares = 0, checks_done = 0, cyc = 0;
    pattern_t exp_pat [17] = '{pat_normal, pat_prbs7, pat_prbs15, pat_prbs23,
        pat_ramp, pat_transport, pat_d21_5, pat_k28_5, pat_ila, pat_rpat,
        pat_low, pat_high, pat_normal, pat_prbs9, pat_prbs31, pat_clock,
        pat_k28_7};
    always #12.5 pclk = ~pclk;
    link_ctrl_regs u_link_ctrl_regs (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .single_ended_sync_pin(se_pin),
        .timestamp_pin(ts_pin), .side_a_lane_on(lane_a),
        .side_b_lane_on(lane_b), .sync_request_n(sync_request_n),
        .sample_number_format(fmt), .scramble_active(scrambler_enable),
        .pattern_sel(pattern_sel), .pattern_unsupported(pat_bad),
        .link_a_ila_id(id_a), .link_b_ila_id(id_b),
        .link_block_reset(blk_rst), .serializer_power_on(ser_on),
        .link_clock_on(clk_on));
    sync_request_model u_sync_request_model (.pclk(pclk),
        .want_pin_sync(want_pin), .want_ts_sync(want_ts),
        .single_ended_sync_pin(se_pin), .timestamp_pin(ts_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // ends one edge after release so derived outputs have settled
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready and prdata are judged at the edge that ends the access
        @(posedge pclk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        if (n >= 40) miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic rdchk(input logic [13:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // link is stopped around every control or test change
    task automatic cfg(input logic [13:0] a, input logic [31:0] d,
                       input logic [31:0] en);
        apb(1'b1, link_enable_addr, 32'h02);
        apb(1'b1, a, d);
        apb(1'b1, link_enable_addr, en);
    endtask
    task automatic ask(input logic p, input logic t);
        @(posedge pclk);
        want_pin <= p;
        want_ts <= t;
        repeat (8) @(posedge pclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk(link_control_addr, 32'h03);
        rdchk(link_test_pattern_addr, 32'h00);
        rdchk(link_device_id_addr, 32'h00);
        chk(er, 1'b0);
        chk(lane_a, 8'h0f);
        chk(id_b, 8'h01);
    endtask
    task automatic t_lanes;
        cfg(link_control_addr, 32'hf3, 32'h03);
        rdchk(link_control_addr, 32'h13);
        chk(lane_a, 8'hf0);
        chk(lane_b, 8'hf0);
        apb(1'b1, link_enable_addr, 32'h02);
        chk(lane_a, 8'h00);
        chk(ser_on, 1'b0);
        chk(blk_rst, 1'b1);
        chk(clk_on, 1'b0);
        cfg(link_control_addr, 32'h03, 32'h03);
        chk(lane_b, 8'h0f);
        chk(clk_on, 1'b1);
    endtask
    task automatic t_format;
        cfg(link_control_addr, 32'h00, 32'h03);
        chk(fmt, 1'b0);
        chk(scrambler_enable, 1'b0);
        cfg(link_control_addr, 32'h00, 32'h0b);
        chk(scrambler_enable, 1'b1);
        cfg(link_control_addr, 32'h03, 32'h03);
        chk(fmt, 1'b1);
        chk(scrambler_enable, 1'b1);
    endtask
    task automatic t_sync;
        ask(1'b1, 1'b0);
        chk(sync_request_n, 1'b0);
        ask(1'b0, 1'b0);
        chk(sync_request_n, 1'b1);
        cfg(link_control_addr, 32'h0b, 32'h03);
        ask(1'b1, 1'b0);
        chk(sync_request_n, 1'b1);
        apb(1'b1, link_enable_addr, 32'h01);
        chk(sync_request_n, 1'b0);
        apb(1'b1, link_enable_addr, 32'h03);
        chk(sync_request_n, 1'b1);
        ask(1'b0, 1'b0);
        cfg(link_control_addr, 32'h07, 32'h07);
        ask(1'b0, 1'b1);
        chk(sync_request_n, 1'b0);
        apb(1'b1, link_enable_addr, 32'h03);
        chk(sync_request_n, 1'b1);
        apb(1'b1, link_enable_addr, 32'h07);
        chk(sync_request_n, 1'b0);
        ask(1'b0, 1'b0);
        chk(sync_request_n, 1'b1);
        cfg(link_control_addr, 32'h03, 32'h03);
    endtask
    task automatic t_pattern;
        for (int i = 0; i < 17; i++) begin
            cfg(link_test_pattern_addr, 32'(i), 32'h03);
            chk(pattern_sel, exp_pat[i]);
            chk(pat_bad, 1'b0);
        end
        cfg(link_test_pattern_addr, 32'hf2, 32'h0b);
        rdchk(link_test_pattern_addr, 32'h12);
        chk(pattern_sel, pat_normal);
        cfg(link_test_pattern_addr, 32'h07, 32'h0b);
        chk(pat_bad, 1'b1);
        chk(pattern_sel, pat_normal);
        rdchk(link_status_addr, 32'h01);
        cfg(link_test_pattern_addr, 32'h00, 32'h03);
    endtask
    task automatic t_id;
        apb(1'b1, link_device_id_addr, 32'h35);
        rdchk(link_device_id_addr, 32'h34);
        chk(id_a, 8'h34);
        chk(id_b, 8'h35);
        apb(1'b1, link_device_id_addr, 32'hff);
        chk(id_b, 8'hff);
        apb(1'b1, 14'h0900, 32'hff);
        chk(er, 1'b1);
        rdchk(14'h0900, 32'h0);
        chk(er, 1'b1);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, want_pin, want_ts} = 6'h00;
        paddr = 14'h0000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lanes();
        t_format();
        t_sync();
        t_pattern();
        t_id();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        complete_run();
    end
endmodule // serial_link_control_regs_tb_top
